// ===== sim/glyph_map_checker.sv
`timescale 1ns/1ns
`default_nettype none
module glyph_map_checker (
  input wire logic                         sys_clk,     // Clock
  input wire logic                         rstn,        // Reset, active low
  input wire glyph_map_pkg::host_byte_t    host_in,     // Host byte
  input wire logic                         host_ready,  // Device ready
  input wire glyph_map_pkg::mem_write_t    mem_wr,      // Memory write
  input wire logic [7:0]                   scan_code,   // Code under scan
  input wire logic [2:0]                   scan_line,   // Line index
  input wire glyph_map_pkg::glyph_fetch_t  fetch,       // Pattern fetch
  input wire logic [4:0]                   block_index, // Block index
  input wire logic                         rom_mode     // ROM mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // A data byte taken this cycle; writes and block index changes may only follow one
  wire byte_in = host_in.valid && !host_in.is_cmd;
  property p_fetch_addr; $past(rstn) |-> fetch.addr == {$past(block_index), $past(scan_code), $past(scan_line)}; endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");
  property p_fetch_user; $past(rstn) |-> fetch.user == (!$past(rom_mode) || $past(scan_code[7])); endproperty
  a_fetch_user: assert property (p_fetch_user) else $error("fetch source wrong");
  property p_upper_half; $past(rstn) && $past(rom_mode) && fetch.user |-> fetch.addr[10]; endproperty
  a_upper_half: assert property (p_upper_half) else $error("lower half used");
  property p_block_hold; $changed(block_index) |-> $past(byte_in); endproperty
  a_block_hold: assert property (p_block_hold) else $error("block moved alone");
  property p_mem_cause; mem_wr.valid |-> $past(byte_in) && mem_wr.data == $past(host_in.data); endproperty
  a_mem_cause: assert property (p_mem_cause) else $error("write without byte");
  property p_mem_quiet; !byte_in |=> !mem_wr.valid; endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("spurious write");
  property p_mode; $changed(rom_mode) |-> $past(host_in.valid && host_in.is_cmd) && rom_mode == ($past(host_in.data) == 8'h80); endproperty
  a_mode: assert property (p_mode) else $error("mode change wrong");
  property p_ready; host_ready; endproperty
  a_ready: assert property (p_ready) else $error("device stalled");
  c_user_fetch: cover property (fetch.user && fetch.addr == 16'hE400);
  c_write: cover property (mem_wr.valid);
  c_block: cover property ($changed(block_index));
endmodule // glyph_map_checker
bind user_glyph_area_mapping glyph_map_checker chk (.sys_clk(sys_clk), .rstn(rstn),
  .host_in(host_in), .host_ready(host_ready), .mem_wr(mem_wr), .scan_code(scan_code),
  .scan_line(scan_line), .fetch(fetch), .block_index(block_index), .rom_mode(rom_mode));
`default_nettype wire

// ===== sim/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic                      sys_clk,    // Clock
  input  wire logic                      host_ready, // Device ready
  output var glyph_map_pkg::host_byte_t  host_in     // Byte to device
);
  initial host_in = '0;
  // One byte per edge, sent once status says ready or after four edges of waiting
  task automatic put(input logic c, input logic [7:0] d);
    repeat (4) if (host_ready !== 1'b1) @(posedge sys_clk);
    host_in <= {1'b1, c, d};
    @(posedge sys_clk);
  endtask
  // Released lines show the inverse so stale data is never mistaken
  task automatic idle;
    host_in <= {1'b0, ~host_in.is_cmd, ~host_in.data};
    @(posedge sys_clk);
  endtask
  // Command with two argument bytes, low byte first
  task automatic cmd2(input logic [7:0] c, input logic [15:0] a);
    put(1'b1, c);
    put(1'b0, a[7:0]);
    put(1'b0, a[15:8]);
    idle;
  endtask
endmodule // host_model
`default_nettype wire

// ===== sim/user_glyph_area_mapping_bench.sv
`timescale 1ns/1ns
`default_nettype none
module user_glyph_area_mapping_bench;
  typedef struct packed {logic [7:0] mode; logic [7:0] code; logic [2:0] line;
                         logic user; logic [15:0] addr;} row_t;
  logic                         sys_clk = 1'b0;
  logic                         rstn = 1'b0;
  logic [7:0]                   scan_code = 8'h00;
  logic [2:0]                   scan_line = 3'h0;
  logic [15:0]                  row_start = 16'h0100;
  logic                         host_ready;
  logic [15:0]                  next_row;
  logic [4:0]                   block_index;
  logic                         rom_mode;
  glyph_map_pkg::host_byte_t    host_in;
  glyph_map_pkg::mem_write_t    mem_wr;
  glyph_map_pkg::glyph_fetch_t  fetch;
  glyph_map_pkg::mem_write_t    wr_log [$];
  int                           fails = 0;
  int                           comparisons = 0;
  // Mode, code, line, expected source and pattern address with block 1Ch
  row_t rows [5] = '{'{8'h80, 8'h80, 3'h0, 1'b1, 16'hE400}, '{8'h80, 8'h7F, 3'h3, 1'b0, 16'hE3FB},
                     '{8'h80, 8'hFF, 3'h7, 1'b1, 16'hE7FF}, '{8'h88, 8'h05, 3'h2, 1'b1, 16'hE02A},
                     '{8'h88, 8'h80, 3'h0, 1'b1, 16'hE400}};
  always #25 sys_clk = ~sys_clk;
  user_glyph_area_mapping uut (.sys_clk(sys_clk), .rstn(rstn), .host_in(host_in),
    .host_ready(host_ready), .mem_wr(mem_wr), .scan_code(scan_code), .scan_line(scan_line),
    .fetch(fetch), .row_start(row_start), .next_row(next_row), .block_index(block_index),
    .rom_mode(rom_mode));
  host_model host (.sys_clk(sys_clk), .host_ready(host_ready), .host_in(host_in));
  // Log every memory write at the edge where it stands
  always @(posedge sys_clk) if (mem_wr.valid === 1'b1) wr_log.push_back(mem_wr);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run needs about seventy cycles
  initial begin
    repeat (500) @(posedge sys_clk);
    fails++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    #1 chk({block_index, rom_mode, mem_wr.valid}, 7'h02);
    chk(next_row, 16'h011E);
    @(posedge sys_clk);
    host.cmd2(8'h22, 16'h00FC);
    host.cmd2(8'h24, 16'hE400);
    host.put(1'b1, 8'hC0);
    host.put(1'b0, 8'hAA);
    host.put(1'b1, 8'hC0);
    host.put(1'b0, 8'h55);
    host.cmd2(8'h24, 16'h0000);
    host.put(1'b1, 8'hC0);
    host.put(1'b0, 8'h80);
    repeat (2) host.idle;
    chk(wr_log.size(), 3);
    chk({wr_log[0].addr, wr_log[0].data}, 24'hE400AA);
    chk({wr_log[1].addr, wr_log[1].data}, 24'hE40155);
    chk({wr_log[2].addr, wr_log[2].data}, 24'h000080);
    // Mode and scan codes per row; fetch answers one cycle after the scan inputs
    foreach (rows[i]) begin
      host.put(1'b1, rows[i].mode);
      host.idle;
      scan_code <= rows[i].code;
      scan_line <= rows[i].line;
      @(posedge sys_clk);
      #1 chk({fetch.user, fetch.addr, fetch.rom_code},
             {rows[i].user, rows[i].addr, rows[i].code});
      @(posedge sys_clk);
    end
    // Offset command cut short by a new command: block must stay at 1Ch
    host.put(1'b1, 8'h22);
    host.put(1'b0, 8'h05);
    host.cmd2(8'h24, 16'hE408);
    // Auto writes step the pointer; the holding single write does not
    host.put(1'b1, 8'hB0);
    host.put(1'b0, 8'h11);
    host.put(1'b0, 8'h22);
    host.put(1'b1, 8'hB2);
    host.put(1'b1, 8'hC4);
    host.put(1'b0, 8'h33);
    host.put(1'b1, 8'hC4);
    host.put(1'b0, 8'h44);
    repeat (2) host.idle;
    chk(wr_log.size(), 7);
    chk({wr_log[3].addr, wr_log[3].data}, 24'hE40811);
    chk({wr_log[4].addr, wr_log[4].data}, 24'hE40922);
    chk({wr_log[5].addr, wr_log[5].data}, 24'hE40A33);
    chk({wr_log[6].addr, wr_log[6].data}, 24'hE40A44);
    host.cmd2(8'h41, 16'h0020);
    #1 chk(next_row, 16'h0120);
    chk(block_index, 5'h1C);
    // Reset in mid-run brings every setting back to its default
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    #1 chk({block_index, rom_mode, mem_wr.valid}, 7'h02);
    chk(next_row, 16'h011E);
    close_out;
  end
endmodule // user_glyph_area_mapping_bench
`default_nettype wire

// ===== src/glyph_map_cfg.svh
`ifndef GLYPH_MAP_CFG_SVH
`define GLYPH_MAP_CFG_SVH

// Host command codes
`define CMD_SET_OFFSET     8'h22
`define CMD_SET_ADDR       8'h24
`define CMD_SET_ROW_WIDTH  8'h41
`define CMD_WRITE_INC      8'hC0
`define CMD_WRITE_HOLD     8'hC4
`define CMD_AUTO_WRITE     8'hB0
`define CMD_AUTO_RESET     8'hB2
`define CMD_MODE_ROM       8'h80
`define CMD_MODE_USER      8'h88

// Glyph address field layout
`define BLOCK_BITS         5
`define LINE_BITS          3
`define USER_RANGE_BIT     7
`define HALF_SEL_BIT       10

// Reset values
`define BLOCK_RESET        5'h00
`define ROW_WIDTH_RESET    8'h1E

`endif

// ===== src/glyph_map_pkg.sv
package glyph_map_pkg;

  typedef struct packed {
    logic       valid;
    logic       is_cmd;
    logic [7:0] data;
  } host_byte_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_write_t;

  typedef struct packed {
    logic        user;
    logic [15:0] addr;
    logic [7:0]  rom_code;
  } glyph_fetch_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARG1,
    ST_ARG2,
    ST_AUTO
  } cmd_state_t;

endpackage

// ===== src/user_glyph_area_mapping.sv
`timescale 1ns/1ns
`default_nettype none
`include "glyph_map_cfg.svh"

// Notes on behaviour
// - Low five bits of first offset byte
// - ROM mode uses upper half only
// - Code 80h at block E000h fetches E400h
// - Block is 2 kByte, 2 kByte aligned
// - User codes draw from user area
// - Row width sets next row start
// - Address is offset, code, line index
// - ROM mode splits codes at 80h
// - Pointer command 24h, low then high
// - Offset command 22h, two data bytes
module user_glyph_area_mapping (
  input  wire logic                        sys_clk,     // System clock, 20 MHz
  input  wire logic                        rstn,        // Synchronous reset, active low
  input  wire glyph_map_pkg::host_byte_t   host_in,     // Command or data byte from host
  output logic                             host_ready,  // Device takes a byte this cycle
  output glyph_map_pkg::mem_write_t        mem_wr,      // Display memory write
  input  wire logic [7:0]                  scan_code,   // Character code under scan
  input  wire logic [2:0]                  scan_line,   // Line-scan index in the glyph
  output glyph_map_pkg::glyph_fetch_t      fetch,       // Glyph pattern fetch request
  input  wire logic [15:0]                 row_start,   // Start address of current row
  output logic [15:0]                      next_row,    // Start address of the next row
  output logic [4:0]                       block_index, // Programmed glyph block index
  output logic                             rom_mode     // Built-in glyph ROM in use
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  glyph_map_pkg::cmd_state_t state_q, state_d;
  logic [7:0]  cmd_q;          // Command awaiting its data bytes
  logic [7:0]  arg1_q;         // First data byte of the pending command
  logic [15:0] addr_ptr_q;     // Display memory address pointer
  logic [4:0]  block_q;        // Glyph block index
  logic [7:0]  row_width_q;    // Bytes per display row
  logic        rom_mode_q;     // High while built-in ROM serves low codes
  glyph_map_pkg::mem_write_t wr_q;
  glyph_map_pkg::glyph_fetch_t fetch_q;

  // ----------------------------------------------------------------
  // Decode of incoming bytes
  // ----------------------------------------------------------------
  // Device never stalls; the host status check is thus always satisfied
  assign host_ready = 1'b1;

  wire is_cmd  = host_in.valid & host_in.is_cmd;
  wire is_data = host_in.valid & ~host_in.is_cmd;

  // Commands that carry two data bytes
  function automatic logic two_arg(input logic [7:0] c);
    two_arg = (c == `CMD_SET_OFFSET) | (c == `CMD_SET_ADDR) | (c == `CMD_SET_ROW_WIDTH);
  endfunction

  // Commands that carry one data byte to be written at the pointer
  function automatic logic one_write(input logic [7:0] c);
    one_write = (c == `CMD_WRITE_INC) | (c == `CMD_WRITE_HOLD);
  endfunction

  wire second_byte = is_data & (state_q == glyph_map_pkg::ST_ARG2);
  wire write_single = is_data & (state_q == glyph_map_pkg::ST_ARG1) & one_write(cmd_q);
  wire write_auto = is_data & (state_q == glyph_map_pkg::ST_AUTO);
  wire do_write = write_single | write_auto;
  // Pointer steps after auto writes and the incrementing single write
  wire ptr_step = write_auto | (write_single & (cmd_q == `CMD_WRITE_INC));
  wire set_off = second_byte & (cmd_q == `CMD_SET_OFFSET);
  wire set_ptr = second_byte & (cmd_q == `CMD_SET_ADDR);
  wire set_row = second_byte & (cmd_q == `CMD_SET_ROW_WIDTH);

  // Single-byte command decodes, shared by the sequencer and the settings;
  // unknown commands match none of these, though one landing mid-sequence still aborts it to idle
  wire cmd_arg  = is_cmd & (two_arg(host_in.data) | one_write(host_in.data));
  wire cmd_auto = is_cmd & (host_in.data == `CMD_AUTO_WRITE);
  wire cmd_stop = is_cmd & (host_in.data == `CMD_AUTO_RESET);
  wire cmd_rom  = is_cmd & (host_in.data == `CMD_MODE_ROM);
  wire cmd_user = is_cmd & (host_in.data == `CMD_MODE_USER);

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  // A new command aborts an unfinished argument sequence (auto mode ends only on B2h), so a lost
  // byte on the host side cannot leave the decoder stuck.
  always_comb begin
    state_d = state_q;
    case (state_q)
      glyph_map_pkg::ST_IDLE: begin
        if (cmd_arg) begin
          state_d = glyph_map_pkg::ST_ARG1;
        end else if (cmd_auto) begin
          state_d = glyph_map_pkg::ST_AUTO;
        end
      end
      glyph_map_pkg::ST_ARG1: begin
        if (is_data) begin
          state_d = two_arg(cmd_q) ? glyph_map_pkg::ST_ARG2 : glyph_map_pkg::ST_IDLE;
        end
      end
      glyph_map_pkg::ST_ARG2: begin
        if (is_data) begin
          state_d = glyph_map_pkg::ST_IDLE;
        end
      end
      glyph_map_pkg::ST_AUTO: begin
        if (cmd_stop) begin
          state_d = glyph_map_pkg::ST_IDLE;
        end
      end
      default: state_d = glyph_map_pkg::ST_IDLE;
    endcase
    // A command landing mid-sequence starts afresh; an auto-write start
    // must not be lost here, or its data bytes would be dropped silently
    if (is_cmd && (state_q == glyph_map_pkg::ST_ARG1 || state_q == glyph_map_pkg::ST_ARG2)) begin
      if (cmd_arg) begin
        state_d = glyph_map_pkg::ST_ARG1;
      end else if (cmd_auto) begin
        state_d = glyph_map_pkg::ST_AUTO;
      end else begin
        state_d = glyph_map_pkg::ST_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= glyph_map_pkg::ST_IDLE;
      cmd_q   <= 8'h00;
      arg1_q  <= 8'h00;
    end else begin
      state_q <= state_d;
      if (is_cmd) cmd_q <= host_in.data;
      if (is_data && state_q == glyph_map_pkg::ST_ARG1) arg1_q <= host_in.data;
    end
  end

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  // Block index changes only on a completed offset command
  // Second offset byte is accepted but unused; only its arrival matters
  // Mode commands carry no data bytes and take effect at once, even when
  // they cut short a pending argument sequence
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      block_q     <= `BLOCK_RESET;
      row_width_q <= `ROW_WIDTH_RESET;
      rom_mode_q  <= 1'b1;
    end else begin
      if (set_off) block_q <= arg1_q[`BLOCK_BITS-1:0];
      if (set_row) row_width_q <= arg1_q;
      if (cmd_rom)  rom_mode_q <= 1'b1;
      if (cmd_user) rom_mode_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Address pointer and memory writes
  // ----------------------------------------------------------------
  // Pattern loads and text writes share this path
  // The pointer wraps from FFFFh to 0000h; no write is refused at the top
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      addr_ptr_q <= 16'h0000;
      wr_q       <= '0;
    end else begin
      if (set_ptr) begin
        addr_ptr_q <= {host_in.data, arg1_q};
      end else if (ptr_step) begin
        addr_ptr_q <= addr_ptr_q + 16'h0001;
      end
      wr_q.valid <= do_write;
      if (do_write) begin
        wr_q.addr <= addr_ptr_q;
        wr_q.data <= host_in.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Glyph pattern address
  // ----------------------------------------------------------------
  // Block, code, line packed into 16 bits: 2 kByte aligned blocks
  wire        code_user  = ~rom_mode_q | scan_code[`USER_RANGE_BIT];
  wire [15:0] glyph_addr = {block_q, scan_code, scan_line};
  // In ROM mode user codes all have bit 7 set, landing in the upper
  // half of the block, e.g. 80h at E000h block reads E400h
  wire        half_ok    = ~rom_mode_q | glyph_addr[`HALF_SEL_BIT];

  // Registered so the memory port sees a clean address; the price is one
  // cycle of latency behind the scan inputs
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fetch_q <= '0;
    end else begin
      fetch_q.user     <= code_user & half_ok;
      fetch_q.addr     <= glyph_addr;
      fetch_q.rom_code <= scan_code;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Next row start from the programmed width
  // The sum wraps inside the 64 kByte space; nothing flags a carry out,
  // so the host keeps its rows below the top of memory
  wire [15:0] row_step = {8'h00, row_width_q};
  assign next_row    = row_start + row_step;
  assign mem_wr      = wr_q;
  assign fetch       = fetch_q;
  assign block_index = block_q;
  assign rom_mode    = rom_mode_q;

endmodule // user_glyph_area_mapping

`default_nettype wire
